// [logic/csw_top.sv]
// Clock status, USB and programmable clock dividers, interrupt mask and wake logic.
// Assumes source clocks well below hclk/2; they are sampled, not used as clocks.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csw_cfg.svh"

// Summary of operation
// R01: PLL B halving bit 0 passes PLL B clock; 1 divides it by two.
// R02: USB source bit 0 picks PLL A, 1 picks PLL B.
// R03: USB clock equals selected input divided by divider field plus one.
// R04: Prog clock source: 0 slow, 1 main, 2 PLL A, 3 PLL B, 4 master.
// R05: Prog prescaler 0..6 divides source by 1,2,4,8,16,32,64.
// R06: USB, prog clock, wake and polarity writes work only with protection off.
// R07: Enable register sets enables at event bits 0-3, 8-10 and 16-18.
// R08: Write-only disable register clears enables, same bit layout.
// R09: Read-only mask register shows which event interrupts are enabled.
// R10: Crystal and RC stable status bits read 1 once each oscillator settles.
// R11: Status bits 1 and 2 show PLL A and PLL B lock.
// R12: Bit 3 shows master clock ready; bits 8 to 10 prog clocks ready.
// R13: Bit 7 reads 0 for internal RC slow clock, 1 for 32 kHz oscillator.
// R14: Bit 16 reads 0 during main oscillator switch, 1 when done.
// R15: Bit 18 latches a clock failure until the status register is read.
// R16: Bit 19 shows live clock failure, bit 20 the fault output.
// R17: Wake enable bits 0..15 let each wake input request fast restart.
// R18: Bits 16..18 let timer, calendar and USB alarms request fast restart.
// R19: Low-power bit clear sends WFI/WFE to sleep; set sends WFE to wait.
// R20: Polarity bits give each wake input its active level.
// R21: Protected write while protection is on sets a flag cleared by reading.
// R22: Interrupt output is high when any enabled status event bit is one.
module csw_top
	import csw_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire csw_clks_t   src_clks,
	input  wire csw_stat_t   osc_status,
	input  wire logic [15:0] wake_in,
	input  wire logic        rtt_alarm,
	input  wire logic        rtc_alarm,
	input  wire logic        usb_alarm,
	input  wire logic        wfi_req,
	input  wire logic        wfe_req,
	output logic             usb_clk,
	output logic [2:0]       prog_clk,
	output logic             irq,
	output logic             fast_restart,
	output logic             sleep_req,
	output logic             wait_req
);

	csw_state_t  r;
	csw_state_t  n;
	csw_async_t  async_in;
	logic [4:0]  lvl;
	logic [4:0]  rise;
	logic        pll_b_eff;
	logic        usb_l;
	logic        usb_r;
	logic [4:0]  half;
	logic        src_l;
	logic        src_r;
	logic        take;
	logic        cf_rise;
	logic        vf_rise;
	logic        prot_wr;
	logic        prot_adr;
	logic [31:0] sr;
	logic [31:0] rd;
	logic [2:0]  idx;
	logic [31:0] pck_a;

	// hsize is not decoded: only whole-word transfers reach this slave
	assign async_in.clk   = src_clks;
	assign async_in.st    = osc_status;
	assign async_in.wake  = wake_in;
	assign async_in.alarm = {usb_alarm, rtc_alarm, rtt_alarm};

	always_comb begin
		n        = r;
		lvl      = 5'h0;
		rise     = 5'h0;
		pll_b_eff = 1'b0;
		usb_l    = 1'b0;
		usb_r    = 1'b0;
		half     = 5'h0;
		src_l    = 1'b0;
		src_r    = 1'b0;
		sr       = `CSW_RST_WORD;
		rd       = `CSW_RST_WORD;
		idx      = 3'h0;
		pck_a    = 32'h0000_0000;
		prot_adr = 1'b0;

		// Two-stage synchronisers; only s2 is read by logic
		n.s1 = async_in;
		n.s2 = r.s1;

		// PLL B halving by a toggle on each synced rising edge
		n.pll_b_prev = r.s2.clk.pll_b_b;
		if (r.s2.clk.pll_b_b && !r.pll_b_prev) begin
			n.pll_b_tog = !r.pll_b_tog; // [R01]
		end
		pll_b_eff = r.pll_b_halving ? r.pll_b_tog : r.s2.clk.pll_b_b; // [R01]

		lvl        = {r.s2.clk.master_clk_choice, pll_b_eff, r.s2.clk.pll_a_a,
		              r.s2.clk.main_clk, r.s2.clk.slow_clk};
		rise       = lvl & ~r.lvl_prev;
		n.lvl_prev = lvl;

		// USB divider; odd ratios give an uneven duty cycle
		usb_l = r.usb_sel ? lvl[CSW_SRC_PLL_B] : lvl[CSW_SRC_PLL_A]; // [R02]
		usb_r = r.usb_sel ? rise[CSW_SRC_PLL_B] : rise[CSW_SRC_PLL_A]; // [R02]
		if (usb_r) begin
			n.usb_cnt = (r.usb_cnt >= r.usb_div) ? 4'h0 : r.usb_cnt + 4'h1; // [R03]
		end
		half      = 5'(({1'b0, r.usb_div} + 5'h01) >> 1);
		n.usb_out = (r.usb_div == 4'h0) ? usb_l : ({1'b0, n.usb_cnt} < half); // [R03]

		// Programmable clocks; reserved source codes freeze the output, which is low with prescaler 0 or 7
		for (int i = 0; i < 3; i++) begin
			if (r.clock_source_sel[i] <= CSW_SRC_MASTER) begin
				src_l = lvl[r.clock_source_sel[i]]; // [R04]
				src_r = rise[r.clock_source_sel[i]]; // [R04]
			end else begin
				src_l = 1'b0;
				src_r = 1'b0;
			end
			if (src_r) begin
				n.pck_cnt[i] = r.pck_cnt[i] + 6'h01;
			end
			idx = r.prescale_sel[i] - 3'h1;
			if (r.prescale_sel[i] == 3'h0) begin
				n.pck_out[i] = src_l; // [R05]
			end else if (r.prescale_sel[i] == 3'h7) begin
				n.pck_out[i] = 1'b0;
			end else begin
				n.pck_out[i] = n.pck_cnt[i][idx]; // [R05]
			end
		end

		// Status word
		sr[`CSW_SR_XTAL]       = r.s2.st.xtal_stable_flag; // [R10]
		sr[`CSW_SR_RCOK]       = r.s2.st.rc_osc_stable_flag; // [R10]
		sr[`CSW_SR_LOCK_A]     = r.s2.st.pll_a_lock_flag; // [R11]
		sr[`CSW_SR_LOCK_B]     = r.s2.st.pll_b_lock_flag; // [R11]
		sr[`CSW_SR_MRDY]       = r.s2.st.master_clock_ready_flag; // [R12]
		sr[`CSW_SR_PCK +: 3]   = r.s2.st.prog_clock_ready_flag; // [R12]
		sr[`CSW_SR_SLOWSEL]    = r.s2.st.slow_osc_source_flag; // [R13]
		sr[`CSW_SR_SWDONE]     = r.s2.st.main_osc_switch_done; // [R14]
		sr[`CSW_SR_CFEV]       = r.cf_event; // [R15]
		sr[`CSW_SR_CFLIVE]     = r.s2.st.clock_fail_live; // [R16]
		sr[`CSW_SR_FAULT]      = r.s2.st.fault_output_flag; // [R16]

		// Address phase; zero wait states, read data captured here
		take      = hsel && hready && htrans[1];
		n.ph_wr   = take && hwrite;
		n.ph_addr = haddr;
		unique case (haddr)
			`CSW_MCKR_ADDR: rd[`CSW_PLL_B_HALF] = r.pll_b_halving;
			`CSW_USB_ADDR:  rd = {20'h0_0000, r.usb_div, 7'h00, r.usb_sel};
			`CSW_SR_ADDR:   rd = sr;
			`CSW_IMR_ADDR:  rd = r.imr; // [R09]
			`CSW_FSMR_ADDR: rd = r.fsmr;
			`CSW_FSPR_ADDR: rd = {16'h0000, r.fspr};
			`CSW_WPMR_ADDR: rd[0] = r.wp_on;
			`CSW_WPSR_ADDR: rd[0] = r.wp_viol;
			default:        rd = `CSW_RST_WORD;
		endcase
		for (int i = 0; i < 3; i++) begin
			pck_a = `CSW_PCK_ADDR + 32'(i) * `CSW_PCK_STEP;
			if (haddr == pck_a) begin
				rd = {25'h000_0000, r.prescale_sel[i], 1'b0, r.clock_source_sel[i]};
			end
			if (r.ph_addr == pck_a) begin
				prot_adr = 1'b1;
			end
		end
		if (take && !hwrite) begin
			n.rdata = rd;
		end

		// Sticky failure flag; a new failure in the read cycle survives
		cf_rise   = r.s2.st.clock_fail_live && !r.cf_prev;
		n.cf_prev = r.s2.st.clock_fail_live;
		if (take && !hwrite && haddr == `CSW_SR_ADDR) begin
			n.cf_event = 1'b0; // [R15]
		end
		if (cf_rise) begin
			n.cf_event = 1'b1; // [R15]
		end

		// Data phase writes
		prot_adr = prot_adr || r.ph_addr == `CSW_USB_ADDR || r.ph_addr == `CSW_MCKR_ADDR ||
		           r.ph_addr == `CSW_FSMR_ADDR || r.ph_addr == `CSW_FSPR_ADDR;
		prot_wr  = r.ph_wr && prot_adr && r.wp_on;
		if (r.ph_wr && !r.wp_on) begin
			unique case (r.ph_addr)
				`CSW_MCKR_ADDR: n.pll_b_halving = hwdata[`CSW_PLL_B_HALF]; // [R06]
				`CSW_USB_ADDR: begin
					n.usb_sel = hwdata[`CSW_USB_SEL_BIT]; // [R06]
					n.usb_div = hwdata[`CSW_USB_DIV_LSB +: 4]; // [R06]
				end
				`CSW_FSMR_ADDR: n.fsmr = hwdata & `CSW_FSMR_MASK; // [R06]
				`CSW_FSPR_ADDR: n.fspr = hwdata[15:0]; // [R06]
				default: ;
			endcase
			for (int i = 0; i < 3; i++) begin
				if (r.ph_addr == `CSW_PCK_ADDR + 32'(i) * `CSW_PCK_STEP) begin
					n.clock_source_sel[i] = hwdata[`CSW_PCK_SRC_LSB +: 3]; // [R06]
					n.prescale_sel[i]     = hwdata[`CSW_PCK_PRE_LSB +: 3]; // [R06]
				end
			end
		end
		if (r.ph_wr && r.ph_addr == `CSW_IER_ADDR) begin
			n.imr = r.imr | (hwdata & `CSW_EVT_MASK); // [R07]
		end
		if (r.ph_wr && r.ph_addr == `CSW_IDR_ADDR) begin
			n.imr = r.imr & ~hwdata; // [R08]
		end
		if (r.ph_wr && r.ph_addr == `CSW_WPMR_ADDR &&
		    hwdata[31:`CSW_WP_KEY_LSB] == `CSW_WP_KEY) begin
			n.wp_on = hwdata[0];
		end

		// Violation flag; a violation in the read cycle wins over the clear
		vf_rise = prot_wr;
		if (take && !hwrite && haddr == `CSW_WPSR_ADDR) begin
			n.wp_viol = 1'b0; // [R21]
		end
		if (vf_rise) begin
			n.wp_viol = 1'b1; // [R21]
		end

		n.irq = |(sr & r.imr); // [R22]

		// Wake: level match against polarity, gated by enables
		n.restart = |(r.fsmr[15:0] & ~(r.s2.wake ^ r.fspr)) || // [R17] [R20]
		            |(r.fsmr[`CSW_ALARM_LSB +: 3] & r.s2.alarm); // [R18]

		// WFI with the low-power bit set still only sleeps the core
		n.sleep = r.fsmr[`CSW_LOWPWR_BIT] ? wfi_req : (wfi_req || wfe_req); // [R19]
		n.waitm = r.fsmr[`CSW_LOWPWR_BIT] && wfe_req; // [R19]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign hrdata       = r.rdata;
	assign usb_clk      = r.usb_out;
	assign prog_clk     = r.pck_out;
	assign irq          = r.irq;
	assign fast_restart = r.restart;
	assign sleep_req    = r.sleep;
	assign wait_req     = r.waitm;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_halving_toggle: assert property ( // [R01]
		r.pll_b_halving && r.s2.clk.pll_b_b && !r.pll_b_prev |=> r.pll_b_tog != $past(r.pll_b_tog)
	) else $error("PLL B halving toggle missed");

	a_usb_write_prot: assert property ( // [R06]
		r.ph_wr && r.wp_on && r.ph_addr == `CSW_USB_ADDR |=> $stable(r.usb_div) && $stable(r.usb_sel)
	) else $error("USB config changed under protection");

	a_viol_flag_set: assert property ( // [R21]
		prot_wr |=> r.wp_viol
	) else $error("Protection violation not flagged");

	a_irq_enable_set: assert property ( // [R07]
		r.ph_wr && r.ph_addr == `CSW_IER_ADDR
		|=> (r.imr & $past(hwdata) & `CSW_EVT_MASK) == ($past(hwdata) & `CSW_EVT_MASK)
	) else $error("Enable write did not set mask bits");

	a_irq_disable_clr: assert property ( // [R08]
		r.ph_wr && r.ph_addr == `CSW_IDR_ADDR |=> (r.imr & $past(hwdata)) == 32'h0000_0000
	) else $error("Disable write did not clear mask bits");

	a_mask_read_back: assert property ( // [R09]
		take && !hwrite && haddr == `CSW_IMR_ADDR |=> hrdata == $past(r.imr)
	) else $error("Mask read data wrong");

	a_cf_event_sticky: assert property ( // [R15]
		cf_rise |=> r.cf_event ##1 (r.cf_event || $past(take && !hwrite && haddr == `CSW_SR_ADDR))
	) else $error("Clock failure event lost");

	a_cf_event_clear: assert property ( // [R15]
		take && !hwrite && haddr == `CSW_SR_ADDR && !cf_rise |=> !r.cf_event
	) else $error("Status read did not clear failure event");

	a_irq_out_level: assert property ( // [R22]
		|(sr & r.imr) |=> irq
	) else $error("Interrupt output not raised");

	a_wake_restart: assert property ( // [R17] [R20]
		|(r.fsmr[15:0] & ~(r.s2.wake ^ r.fspr)) |=> fast_restart
	) else $error("Enabled wake input gave no restart");

	a_sleep_entry: assert property ( // [R19]
		!r.fsmr[`CSW_LOWPWR_BIT] && (wfi_req || wfe_req) |=> sleep_req && !wait_req
	) else $error("Sleep entry wrong with low-power bit clear");

	a_wait_entry: assert property ( // [R19]
		r.fsmr[`CSW_LOWPWR_BIT] && wfe_req |=> wait_req && sleep_req == $past(wfi_req)
	) else $error("Wait entry wrong with low-power bit set");

	a_alarm_restart: assert property ( // [R18]
		|(r.fsmr[`CSW_ALARM_LSB +: 3] & r.s2.alarm) |=> fast_restart
	) else $error("Enabled alarm gave no restart");

	a_wake_write_prot: assert property ( // [R06]
		r.ph_wr && r.wp_on && (r.ph_addr == `CSW_FSMR_ADDR || r.ph_addr == `CSW_FSPR_ADDR)
		|=> $stable(r.fsmr) && $stable(r.fspr)
	) else $error("Wake config changed under protection");

	a_viol_read_clear: assert property ( // [R21]
		take && !hwrite && haddr == `CSW_WPSR_ADDR && !prot_wr |=> !r.wp_viol
	) else $error("Protection status read did not clear flag");

	a_irq_out_low: assert property ( // [R22]
		!(|(sr & r.imr)) |=> !irq
	) else $error("Interrupt output raised with no enabled event");

	a_status_read: assert property ( // [R10] [R11] [R12] [R13] [R14] [R16]
		take && !hwrite && haddr == `CSW_SR_ADDR |=> hrdata == $past(sr)
	) else $error("Status read data wrong");

endmodule : csw_top
`default_nettype wire

// [logic/csw_cfg.svh]
// Addresses, field positions and reset values of the clock status and wake block.
// Assumes an AHB-Lite fabric that presents full 32-bit byte addresses.
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH

`define CSW_MCKR_ADDR   32'h400E_0430
`define CSW_USB_ADDR    32'h400E_0438
`define CSW_PCK_ADDR    32'h400E_0440
`define CSW_PCK_STEP    32'h0000_0004
`define CSW_IER_ADDR    32'h400E_0460
`define CSW_IDR_ADDR    32'h400E_0464
`define CSW_SR_ADDR     32'h400E_0468
`define CSW_IMR_ADDR    32'h400E_046C
`define CSW_FSMR_ADDR   32'h400E_0470
`define CSW_FSPR_ADDR   32'h400E_0474
`define CSW_WPMR_ADDR   32'h400E_04E4
`define CSW_WPSR_ADDR   32'h400E_04E8

`define CSW_USB_SEL_BIT 0
`define CSW_USB_DIV_LSB 8
`define CSW_PCK_SRC_LSB 0
`define CSW_PCK_PRE_LSB 4
`define CSW_PLL_B_HALF  13
`define CSW_LOWPWR_BIT  20
`define CSW_ALARM_LSB   16
`define CSW_WP_KEY_LSB  8
`define CSW_WP_KEY      24'h50_4D43

`define CSW_SR_XTAL     0
`define CSW_SR_LOCK_A   1
`define CSW_SR_LOCK_B   2
`define CSW_SR_MRDY     3
`define CSW_SR_SLOWSEL  7
`define CSW_SR_PCK      8
`define CSW_SR_SWDONE   16
`define CSW_SR_RCOK     17
`define CSW_SR_CFEV     18
`define CSW_SR_CFLIVE   19
`define CSW_SR_FAULT    20

`define CSW_EVT_MASK    32'h0007_070F
`define CSW_FSMR_MASK   32'h0017_FFFF
`define CSW_RST_WORD    32'h0000_0000

`endif

// [logic/csw_pkg.sv]
// Types shared by the clock status and wake block.
// Assumes csw_cfg.svh supplies the addresses and field positions.
package csw_pkg;

	typedef enum logic [2:0] {
		CSW_SRC_SLOW = 3'b000,
		CSW_SRC_MAIN = 3'b001,
		CSW_SRC_PLL_A  = 3'b010,
		CSW_SRC_PLL_B  = 3'b011,
		CSW_SRC_MASTER = 3'b100
	} csw_src_t;

	typedef struct packed {
		logic master_clk_choice;
		logic pll_b_b;
		logic pll_a_a;
		logic main_clk;
		logic slow_clk;
	} csw_clks_t;

	typedef struct packed {
		logic       fault_output_flag;
		logic       clock_fail_live;
		logic       rc_osc_stable_flag;
		logic       main_osc_switch_done;
		logic [2:0] prog_clock_ready_flag;
		logic       slow_osc_source_flag;
		logic       master_clock_ready_flag;
		logic       pll_b_lock_flag;
		logic       pll_a_lock_flag;
		logic       xtal_stable_flag;
	} csw_stat_t;

	typedef struct packed {
		csw_clks_t   clk;
		csw_stat_t   st;
		logic [15:0] wake;
		logic [2:0]  alarm;
	} csw_async_t;

	typedef struct packed {
		csw_async_t       s1;
		csw_async_t       s2;
		logic [4:0]       lvl_prev;
		logic             pll_b_prev;
		logic             pll_b_tog;
		logic             cf_prev;
		logic [3:0]       usb_cnt;
		logic             usb_out;
		logic [2:0][5:0]  pck_cnt;
		logic [2:0]       pck_out;
		logic             usb_sel;
		logic [3:0]       usb_div;
		logic             pll_b_halving;
		logic [2:0][2:0]  clock_source_sel;
		logic [2:0][2:0]  prescale_sel;
		logic [31:0]      imr;
		logic [31:0]      fsmr;
		logic [15:0]      fspr;
		logic             wp_on;
		logic             wp_viol;
		logic             cf_event;
		logic             ph_wr;
		logic [31:0]      ph_addr;
		logic [31:0]      rdata;
		logic             irq;
		logic             restart;
		logic             sleep;
		logic             waitm;
	} csw_state_t;

endpackage : csw_pkg

// [bench/csw_testbench.sv]
// Self-checking bench for the clock status, divider and wake block.
// Assumes csw_top is the only slave on an AHB-Lite bus driven by this bench.
`timescale 1ns/1ps
`default_nettype none
`include "csw_cfg.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module testbench
	import csw_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	csw_clks_t   src_v = '0;
	csw_stat_t   osc_v = '0;
	logic [15:0] wake_v = '0;
	logic [2:0]  alarm_v = '0;
	logic        wfi_v = 1'b0;
	logic        wfe_v = 1'b0;
	logic        usb_clk;
	logic [2:0]  prog_clk;
	logic        irq;
	logic        fast_restart;
	logic        sleep_req;
	logic        wait_req;
	int          err_count = 0;
	int          cmp_count = 0;
	int          half [5] = '{4, 6, 8, 5, 7};
	int          tick [5] = '{default: 0};
	int          rise [9] = '{default: 0};
	logic [8:0]  prev = '0;
	wire logic [8:0] obs = {usb_clk, prog_clk, src_v};

	always #50 hclk = ~hclk;

	csw_top csw_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_clks(src_v),
		.osc_status(osc_v), .wake_in(wake_v), .rtt_alarm(alarm_v[0]),
		.rtc_alarm(alarm_v[1]), .usb_alarm(alarm_v[2]), .wfi_req(wfi_v), .wfe_req(wfe_v),
		.usb_clk(usb_clk), .prog_clk(prog_clk), .irq(irq), .fast_restart(fast_restart),
		.sleep_req(sleep_req), .wait_req(wait_req)
	);

	// Source clocks toggle no faster than every 4 bus cycles, as the sampler needs
	always @(posedge hclk) begin
		for (int i = 0; i < 5; i++) begin
			tick[i] <= (tick[i] == half[i] - 1) ? 0 : tick[i] + 1;
			if (tick[i] == half[i] - 1)
				src_v[i] <= ~src_v[i];
		end
		prev <= obs;
		for (int i = 0; i < 9; i++)
			if (obs[i] && !prev[i])
				rise[i] <= rise[i] + 1;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("FAIL at %0t got %h expected %h", $time, g, e);
		end
	endtask : check_val

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n++ < 20) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n++ < 40) @(posedge hclk);
		r = hrdata;
		if (n >= 40)
			err_count++;
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		`CHK(r, e);
	endtask : rc

	function automatic logic [31:0] sr_of(logic [11:0] s, logic ev);
		return {11'h000, s[11:10], ev, s[9:8], 5'h00, s[7:4], 3'h0, s[3:0]};
	endfunction : sr_of

	// Edge counts drift by one with divider phase, so one edge of slack
	function automatic int near(int g, int e);
		return (g >= e - 1 && g <= e + 1) ? e : g;
	endfunction : near

	task automatic measure(input int o, input int s, input int div);
		int a;
		int b;
		repeat (8) @(posedge hclk);
		a = rise[o];
		b = rise[s];
		repeat (2048) @(posedge hclk);
		a = rise[o] - a;
		b = rise[s] - b;
		`CHK(near(a, b / div), b / div);
	endtask : measure

	task automatic wake_case(input logic [31:0] sm, input logic [15:0] pol,
		input logic [15:0] w, input logic [2:0] al, input logic e);
		wr(`CSW_FSMR_ADDR, sm);
		wr(`CSW_FSPR_ADDR, {16'h0000, pol});
		wake_v <= w;
		alarm_v <= al;
		repeat (6) @(posedge hclk);
		`CHK(fast_restart, e);
	endtask : wake_case

	task automatic lp_case(input logic low_power_select, input logic fi, input logic fe,
		input logic es, input logic ew);
		wr(`CSW_FSMR_ADDR, {11'h000, low_power_select, 20'h0_0000});
		wfi_v <= fi;
		wfe_v <= fe;
		repeat (4) @(posedge hclk);
		`CHK(sleep_req, es);
		`CHK(wait_req, ew);
		wfi_v <= 1'b0;
		wfe_v <= 1'b0;
	endtask : lp_case

	// Whole run is about 33k cycles; 80k cycles means a hang
	initial begin
		#(100 * 80000);
		err_count++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rc(`CSW_IMR_ADDR, 32'h0000_0000);
		wr(`CSW_IER_ADDR, 32'hFFFF_FFFF);
		rc(`CSW_IMR_ADDR, 32'h0007_070F);
		wr(`CSW_IDR_ADDR, 32'h0000_0701);
		rc(`CSW_IMR_ADDR, 32'h0007_000E);
		wr(`CSW_IMR_ADDR, 32'hFFFF_FFFF);
		rc(`CSW_IMR_ADDR, 32'h0007_000E);
		rc(32'h400E_0450, 32'h0000_0000);
		wr(`CSW_IDR_ADDR, 32'hFFFF_FFFF);
		$display("test mask registers done");
		wr(`CSW_IER_ADDR, 32'h0000_0001);
		osc_v <= 12'hAAA;
		repeat (6) @(posedge hclk);
		`CHK(irq, 1'b0);
		rc(`CSW_SR_ADDR, sr_of(12'hAAA, 1'b0));
		osc_v <= 12'h555;
		repeat (6) @(posedge hclk);
		`CHK(irq, 1'b1);
		rc(`CSW_SR_ADDR, sr_of(12'h555, 1'b1));
		rc(`CSW_SR_ADDR, sr_of(12'h555, 1'b0));
		wr(`CSW_IDR_ADDR, 32'h0000_0001);
		osc_v <= 12'h000;
		wr(`CSW_IER_ADDR, 32'h0004_0000);
		osc_v <= 12'h400;
		repeat (6) @(posedge hclk);
		`CHK(irq, 1'b1);
		rc(`CSW_SR_ADDR, sr_of(12'h400, 1'b1));
		repeat (4) @(posedge hclk);
		`CHK(irq, 1'b0);
		$display("test status done");
		wr(`CSW_USB_ADDR, 32'hFFFF_FFFF);
		rc(`CSW_USB_ADDR, 32'h0000_0F01);
		wr(`CSW_WPMR_ADDR, 32'h504D_4301);
		wr(`CSW_USB_ADDR, 32'h0000_0000);
		wr(`CSW_FSPR_ADDR, 32'h0000_FFFF);
		rc(`CSW_USB_ADDR, 32'h0000_0F01);
		rc(`CSW_FSPR_ADDR, 32'h0000_0000);
		rc(`CSW_WPSR_ADDR, 32'h0000_0001);
		rc(`CSW_WPSR_ADDR, 32'h0000_0000);
		wr(`CSW_WPMR_ADDR, 32'h1234_5600);
		wr(`CSW_FSMR_ADDR, 32'h0000_0001);
		rc(`CSW_FSMR_ADDR, 32'h0000_0000);
		rc(`CSW_WPSR_ADDR, 32'h0000_0001);
		wr(`CSW_WPMR_ADDR, 32'h504D_4300);
		wr(`CSW_FSMR_ADDR, 32'hFFFF_FFFF);
		rc(`CSW_FSMR_ADDR, 32'h0017_FFFF);
		$display("test protection done");
		wake_case(32'h0000_8001, 16'h0001, 16'h8000, 3'b000, 1'b0);
		wake_case(32'h0000_8001, 16'h0001, 16'h8001, 3'b000, 1'b1);
		wake_case(32'h0000_8001, 16'h0001, 16'h0000, 3'b000, 1'b1);
		wake_case(32'h0000_0000, 16'h0001, 16'h0001, 3'b000, 1'b0);
		wake_case(32'h0001_0000, 16'h0000, 16'h0000, 3'b001, 1'b1);
		wake_case(32'h0002_0000, 16'h0000, 16'h0000, 3'b010, 1'b1);
		wake_case(32'h0004_0000, 16'h0000, 16'h0000, 3'b100, 1'b1);
		wake_case(32'h0003_0000, 16'h0000, 16'h0000, 3'b100, 1'b0);
		alarm_v <= 3'b000;
		$display("test wake done");
		lp_case(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		lp_case(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		lp_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		lp_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		lp_case(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		$display("test low power done");
		for (int k = 0; k < 5; k++) begin
			wr(`CSW_PCK_ADDR + 32'(4 * (k % 3)), 32'(k) | 32'h0000_0010);
			measure(5 + k % 3, k, 2);
		end
		for (int k = 0; k < 7; k++) begin
			wr(`CSW_PCK_ADDR + 32'(4 * (k % 3)), 32'(k << 4));
			measure(5 + k % 3, 0, 1 << k);
		end
		$display("test programmable clocks done");
		wr(`CSW_USB_ADDR, 32'h0000_0000);
		measure(8, 2, 1);
		wr(`CSW_USB_ADDR, 32'h0000_0001);
		measure(8, 3, 1);
		wr(`CSW_MCKR_ADDR, 32'h0000_2000);
		measure(8, 3, 2);
		wr(`CSW_MCKR_ADDR, 32'h0000_0000);
		wr(`CSW_USB_ADDR, 32'h0000_0201);
		measure(8, 3, 3);
		$display("test usb clock done");
		complete_run();
	end
endmodule : testbench
`default_nettype wire
